//--- hw/prog_mem_pkg.sv
// Shared constants and types for the program memory and table read unit.
// Assumes a core that runs on one clock and a serial programmer that clocks its own link.
package prog_mem_pkg;

  // ****************************************
  // Storage geometry
  // ****************************************
  localparam int WORD_W        = 14;
  localparam int LOW_W         = 8;
  localparam int LATCH_W       = 8;
  localparam int DEST_W        = 7;
  localparam int DEPTH_DEFAULT = 2048;
  localparam int LINK_ADDR_W   = 11;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [LINK_ADDR_W-1:0] RESET_VECTOR = 11'h000;
  localparam logic [WORD_W-1:0]      WORD_RESET   = 14'h0000;
  localparam logic [LATCH_W-1:0]     LATCH_RESET  = 8'h00;
  localparam logic [7:0]             PTR_RESET    = 8'h00;
  localparam int                     LINK_BITS    = 1 + LINK_ADDR_W + WORD_W;
  localparam logic [4:0]             LINK_LAST_IN = 5'h19;
  localparam logic [3:0]             LINK_LAST_OUT = 4'hd;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic                   isRead;
    logic [LINK_ADDR_W-1:0] addr;
    logic [WORD_W-1:0]      data;
  } link_req_t;

  typedef struct packed {
    logic              strobe;
    logic [DEST_W-1:0] addr;
    logic [LOW_W-1:0]  value;
  } data_write_t;

  typedef enum {TAB_IDLE, TAB_SECOND} tab_state_t;
  typedef enum {LINK_SHIFT_IN, LINK_WAIT, LINK_SHIFT_OUT} link_phase_t;

endpackage : prog_mem_pkg

//--- hw/sync_two_flop.sv
// Two flip-flop synchroniser for levels and toggles.
// Assumes each bit changes slowly against the destination clock.
`timescale 1ns/1ps
`default_nettype none
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q_reg
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

endmodule : sync_two_flop
`default_nettype wire

//--- hw/program_memory_table_read.sv
// Program memory with fetch port, table read unit and serial programming link.
// Assumes the core gives pcNext and table requests on clk_sys, and the programmer
// drives progFrame and data together with progSerialClk.
`timescale 1ns/1ps
`default_nettype none
module program_memory_table_read
  import prog_mem_pkg::*;
#(
  parameter int DEPTH    = DEPTH_DEFAULT,
  parameter bit EMULATED = 1'b0
) (
  // Clocks and reset
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic                        progSerialClk,
  // Instruction fetch
  input  wire logic [$clog2(DEPTH)-1:0]    pcNext,
  output logic      [$clog2(DEPTH)-1:0]    fetchAddr_reg,
  output logic      [WORD_W-1:0]           instrWord_reg,
  output logic                             fetchStall_reg,
  // Table pointer writes
  input  wire logic                        ptrWrStb,
  input  wire logic                        ptrWrHigh,
  input  wire logic [7:0]                  ptrWrData,
  output logic      [7:0]                  tblPtrLow_reg,
  output logic      [$clog2(DEPTH)-9:0]    tblPtrHigh_reg,
  // Table read
  input  wire logic                        tabRdReq,
  input  wire logic                        tabRdLastPage,
  input  wire logic [DEST_W-1:0]           tabRdDest,
  output data_write_t                      dataWr_reg,
  output logic      [LATCH_W-1:0]          tableHighLatch_reg,
  // Serial programming and debug pins
  input  wire logic                        progFrame,
  input  wire logic                        progSerialIoIn,
  output logic                             progSerialIoOut_reg,
  output logic                             progSerialIoOeN_reg,
  // Shared pin function
  output logic                             sharedPinFuncEn_reg
);

  localparam int ADDR_W = $clog2(DEPTH);
  localparam int HIGH_W = ADDR_W - 8;

  // ****************************************
  // Storage and helpers
  // ****************************************
  logic [WORD_W-1:0] progMem [DEPTH];
  logic [ADDR_W-1:0] tabAddr_reg;
  logic [DEST_W-1:0] tabDest_reg;
  tab_state_t        tabState_reg;
  logic              tabAccept;
  logic              postReset_reg;

  function automatic logic [ADDR_W-1:0] tableAddr(
    input logic              lastPage,
    input logic [HIGH_W-1:0] high,
    input logic [7:0]        low
  );
    return {(lastPage ? {HIGH_W{1'b1}} : high), low};
  endfunction : tableAddr

  assign tabAccept = tabRdReq && (tabState_reg == TAB_IDLE);

  // ****************************************
  // Instruction fetch
  // ****************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fetchAddr_reg <= RESET_VECTOR[ADDR_W-1:0];
      instrWord_reg <= WORD_RESET;
    end else if (!fetchStall_reg) begin
      fetchAddr_reg <= pcNext;
      instrWord_reg <= progMem[fetchAddr_reg];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      postReset_reg <= 1'b1;
    end else begin
      postReset_reg <= 1'b0;
    end
  end

  // ****************************************
  // Table pointer
  // ****************************************
  // Only the core's write strobe moves the pointer, so repeated reads hit one word.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tblPtrLow_reg  <= PTR_RESET;
      tblPtrHigh_reg <= PTR_RESET[HIGH_W-1:0];
    end else if (ptrWrStb) begin
      if (ptrWrHigh) begin
        tblPtrHigh_reg <= ptrWrData[HIGH_W-1:0];
      end else begin
        tblPtrLow_reg <= ptrWrData;
      end
    end
  end

  // ****************************************
  // Table read sequence
  // ****************************************
  // A request that arrives during the second cycle is ignored, not queued.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tabState_reg   <= TAB_IDLE;
      tabAddr_reg    <= '0;
      tabDest_reg    <= '0;
      fetchStall_reg <= 1'b0;
      dataWr_reg     <= '0;
    end else begin
      case (tabState_reg)
        TAB_IDLE: begin
          dataWr_reg.strobe <= 1'b0;
          if (tabRdReq) begin
            tabAddr_reg    <= tableAddr(tabRdLastPage, tblPtrHigh_reg, tblPtrLow_reg);
            tabDest_reg    <= tabRdDest;
            tabState_reg   <= TAB_SECOND;
            fetchStall_reg <= 1'b1;
          end
        end
        TAB_SECOND: begin
          dataWr_reg.strobe <= 1'b1;
          dataWr_reg.addr   <= tabDest_reg;
          dataWr_reg.value  <= progMem[tabAddr_reg][LOW_W-1:0];
          fetchStall_reg    <= 1'b0;
          tabState_reg      <= TAB_IDLE;
        end
        default: begin
          tabState_reg <= TAB_IDLE;
        end
      endcase
    end
  end

  // No write port exists here, so the latch cannot be saved and restored.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tableHighLatch_reg <= LATCH_RESET;
    end else if (tabState_reg == TAB_SECOND) begin
      tableHighLatch_reg <= LATCH_W'(progMem[tabAddr_reg][WORD_W-1:LOW_W]);
    end
  end

  // ****************************************
  // Serial link, link clock domain
  // ****************************************
  // The link phase, counters and pin drive are cleared whenever the frame is low, so a stopped clock
  // after the frame cannot leave the data pin driven.
  logic              linkRst;
  link_phase_t       linkPhase_reg;
  logic [4:0]        bitCnt_reg;
  logic [3:0]        outCnt_reg;
  logic [WORD_W-1:0] shiftOut_reg;
  logic [LINK_BITS-1:0] shiftIn_reg;
  logic              reqTgl_reg;
  logic              ackSync;
  logic              lastIn;
  logic [WORD_W-1:0] readWord_reg;
  link_req_t         linkReq;

  assign linkRst = reset | ~progFrame;
  assign lastIn  = progFrame && (linkPhase_reg == LINK_SHIFT_IN) && (bitCnt_reg == LINK_LAST_IN);
  assign linkReq = link_req_t'(shiftIn_reg);

  always_ff @(posedge progSerialClk or posedge linkRst) begin
    if (linkRst) begin
      linkPhase_reg       <= LINK_SHIFT_IN;
      bitCnt_reg          <= '0;
      outCnt_reg          <= '0;
      shiftOut_reg        <= '0;
      progSerialIoOut_reg <= 1'b0;
      progSerialIoOeN_reg <= 1'b1;
    end else begin
      case (linkPhase_reg)
        LINK_SHIFT_IN: begin
          progSerialIoOeN_reg <= 1'b1;
          bitCnt_reg          <= bitCnt_reg + 5'h01;
          if (lastIn) begin
            linkPhase_reg <= LINK_WAIT;
          end
        end
        LINK_WAIT: begin
          bitCnt_reg <= '0;
          if (reqTgl_reg == ackSync) begin
            if (linkReq.isRead) begin
              shiftOut_reg  <= readWord_reg;
              outCnt_reg    <= '0;
              linkPhase_reg <= LINK_SHIFT_OUT;
            end else begin
              linkPhase_reg <= LINK_SHIFT_IN;
            end
          end
        end
        LINK_SHIFT_OUT: begin
          progSerialIoOut_reg <= shiftOut_reg[WORD_W-1];
          progSerialIoOeN_reg <= 1'b0;
          shiftOut_reg        <= {shiftOut_reg[WORD_W-2:0], 1'b0};
          outCnt_reg          <= outCnt_reg + 4'h1;
          if (outCnt_reg == LINK_LAST_OUT) begin
            linkPhase_reg <= LINK_SHIFT_IN;
          end
        end
        default: begin
          linkPhase_reg <= LINK_SHIFT_IN;
        end
      endcase
    end
  end

  // The request word and its toggle survive the end of a frame, so the
  // handshake with the system side never sees a half-cleared word.
  always_ff @(posedge progSerialClk or posedge reset) begin
    if (reset) begin
      shiftIn_reg <= '0;
      reqTgl_reg  <= 1'b0;
    end else begin
      if (progFrame && (linkPhase_reg == LINK_SHIFT_IN)) begin
        shiftIn_reg <= {shiftIn_reg[LINK_BITS-2:0], progSerialIoIn};
      end
      if (lastIn) begin
        reqTgl_reg <= ~reqTgl_reg;
      end
    end
  end

  logic ackTgl_reg;

  sync_two_flop #(.WIDTH(1)) ackSyncer (
    .clk   (progSerialClk),
    .reset (reset),
    .d     (ackTgl_reg),
    .q_reg (ackSync)
  );

  // ****************************************
  // Serial link, system side
  // ****************************************
  logic reqSync;
  logic frameSync;
  logic reqSeen_reg;
  logic reqEvent;

  sync_two_flop #(.WIDTH(2)) linkSyncer (
    .clk   (clk_sys),
    .reset (reset),
    .d     ({reqTgl_reg, progFrame}),
    .q_reg ({reqSync, frameSync})
  );

  assign reqEvent = reqSync != reqSeen_reg;

  // The read word settles on the same edge as the acknowledge toggle; the
  // two-flop delay on the link side keeps it stable when sampled there.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reqSeen_reg  <= 1'b0;
      ackTgl_reg   <= 1'b0;
      readWord_reg <= WORD_RESET;
    end else if (reqEvent) begin
      reqSeen_reg <= reqSync;
      ackTgl_reg  <= ~ackTgl_reg;
      if (linkReq.isRead) begin
        readWord_reg <= progMem[linkReq.addr[ADDR_W-1:0]];
      end
    end
  end

  // Flash contents are not cleared by reset.
  always_ff @(posedge clk_sys) begin
    if (reqEvent && !linkReq.isRead) begin
      progMem[linkReq.addr[ADDR_W-1:0]] <= linkReq.data;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sharedPinFuncEn_reg <= 1'b0;
    end else begin
      sharedPinFuncEn_reg <= !EMULATED && !frameSync;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_fetch_reset_vec: assert property (
    postReset_reg |-> fetchAddr_reg == RESET_VECTOR[ADDR_W-1:0])
    else $error("Fetch did not restart at address zero.");

  a_tab_two_cycles: assert property (
    tabAccept |=> fetchStall_reg ##1 (dataWr_reg.strobe && !fetchStall_reg))
    else $error("Table read did not finish in two cycles.");

  a_tab_addr_concat: assert property (
    tabAccept && !tabRdLastPage |=>
      tabAddr_reg == tableAddr(1'b0, $past(tblPtrHigh_reg), $past(tblPtrLow_reg)))
    else $error("Table address is not the joined pointer.");

  a_last_page_addr: assert property (
    tabAccept && tabRdLastPage |=>
      tabAddr_reg == {{HIGH_W{1'b1}}, $past(tblPtrLow_reg)})
    else $error("Last page read used the wrong address.");

  a_low_byte_write: assert property (
    dataWr_reg.strobe |->
      dataWr_reg.value == progMem[$past(tabAddr_reg)][LOW_W-1:0] && dataWr_reg.addr == $past(tabDest_reg))
    else $error("Low table byte or destination is wrong.");

  a_high_latch_load: assert property (
    dataWr_reg.strobe |-> tableHighLatch_reg[WORD_W-LOW_W-1:0] == progMem[$past(tabAddr_reg)][WORD_W-1:LOW_W])
    else $error("High latch does not hold the upper word bits.");

  a_latch_unused_zero: assert property (
    dataWr_reg.strobe |-> tableHighLatch_reg[LATCH_W-1:WORD_W-LOW_W] == '0)
    else $error("Unused latch bits are not zero.");

  a_latch_read_only: assert property (
    tabState_reg != TAB_SECOND |=> $stable(tableHighLatch_reg))
    else $error("High latch changed outside a table read.");

  a_pointer_kept: assert property (
    !ptrWrStb |=> $stable(tblPtrLow_reg) && $stable(tblPtrHigh_reg))
    else $error("Table pointer changed without a write.");

  a_fetch_stall_hold: assert property (
    fetchStall_reg |=> fetchAddr_reg == $past(fetchAddr_reg) && $stable(instrWord_reg))
    else $error("Fetch moved during the table read stall.");

  a_emul_pins_quiet: assert property (
    EMULATED || frameSync |=> !sharedPinFuncEn_reg)
    else $error("Shared pin function active while it must be off.");

  a_link_drive_window: assert property (
    @(posedge progSerialClk) disable iff (linkRst)
    !progSerialIoOeN_reg |-> $past(linkPhase_reg) == LINK_SHIFT_OUT)
    else $error("Data pin driven outside the read-back phase.");

endmodule : program_memory_table_read
`default_nettype wire

//--- sim/prog_link_model.sv
// Serial programmer model: frames commands on the shared programming and debug pins.
// Assumes the device samples on rising link clock edges and drives read-back bits from them.
`timescale 1ns/1ps
`default_nettype none
module prog_link_model
  import prog_mem_pkg::*;
(
  // Link pins
  output logic progSerialClk,
  output logic progFrame,
  output logic progSerialIoIn,
  // Device drive of the data pin
  input  wire logic progSerialIoOut_reg,
  input  wire logic progSerialIoOeN_reg
);
  logic driveBit = 1'b0;

  initial begin
    progSerialClk = 1'b0;
    progFrame     = 1'b0;
  end

  // The programmer lets go of the line while the device drives it.
  assign progSerialIoIn = progSerialIoOeN_reg ? driveBit : progSerialIoOut_reg;

  // The clock only comes from this side; between frames it runs only in pulses.
  task automatic tick();
    #16 progSerialClk = 1'b1;
    #16 progSerialClk = 1'b0;
  endtask : tick

  task automatic pulses(input int n);
    repeat (n) tick();
  endtask : pulses

  task automatic frame(input link_req_t req, output logic [WORD_W-1:0] word, output bit ok);
    int i;
    word = '0;
    #($urandom_range(31, 1));
    progFrame = 1'b1;
    for (i = LINK_BITS - 1; i >= 0; i--) begin
      driveBit = req[i];
      tick();
    end
    // Keep clocking through the handshake; a toggling bit shows that the input is ignored.
    i = 0;
    while (i < 40 && (req.isRead ? progSerialIoOeN_reg === 1'b1 : i < 12)) begin
      driveBit = ~driveBit;
      tick();
      i++;
    end
    ok = (i < 40);
    for (i = 0; req.isRead && i < WORD_W; i++) begin
      word = {word[WORD_W-2:0], progSerialIoIn};
      tick();
    end
    ok = ok && progSerialIoOeN_reg === 1'b1;
    progFrame = 1'b0;
    driveBit  = ~driveBit;
  endtask : frame
endmodule : prog_link_model
`default_nettype wire

//--- sim/program_memory_table_read_tb.sv
// Self-checking bench for the program memory and table read unit.
// Assumes memory is loaded only through the serial link model before fetch and table reads.
`timescale 1ns/1ps
`default_nettype none
module program_memory_table_read_tb
  import prog_mem_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              reset   = 1'b1;
  logic              progSerialClk, progFrame, progSerialIoIn;
  logic [10:0]       pcNext, fetchAddr_reg;
  logic [13:0]       instrWord_reg;
  logic              fetchStall_reg, ptrWrStb, ptrWrHigh, tabRdReq, tabRdLastPage;
  logic [7:0]        ptrWrData, tblPtrLow_reg, tableHighLatch_reg;
  logic [2:0]        tblPtrHigh_reg;
  logic [6:0]        tabRdDest;
  data_write_t       dataWr_reg;
  logic              progSerialIoOut_reg, progSerialIoOeN_reg, sharedPinFuncEn_reg, prevStall = 1'b0;
  logic [13:0]       img [int];
  logic [22:0]       expQ [$];
  logic [22:0]       e;
  logic [13:0]       w;
  bit                ok;
  int                bad_count = 0;
  int                n_tests   = 0;
  int                addrs [5] = '{0, 'h305, 'h306, 'h7ff, 'h100};

  always #20 clk_sys = ~clk_sys;

  program_memory_table_read #(.DEPTH(2048), .EMULATED(1'b0)) uut (
    .clk_sys(clk_sys), .reset(reset), .progSerialClk(progSerialClk), .pcNext(pcNext),
    .fetchAddr_reg(fetchAddr_reg), .instrWord_reg(instrWord_reg), .fetchStall_reg(fetchStall_reg),
    .ptrWrStb(ptrWrStb), .ptrWrHigh(ptrWrHigh), .ptrWrData(ptrWrData), .tblPtrLow_reg(tblPtrLow_reg),
    .tblPtrHigh_reg(tblPtrHigh_reg), .tabRdReq(tabRdReq), .tabRdLastPage(tabRdLastPage),
    .tabRdDest(tabRdDest), .dataWr_reg(dataWr_reg), .tableHighLatch_reg(tableHighLatch_reg),
    .progFrame(progFrame), .progSerialIoIn(progSerialIoIn), .progSerialIoOut_reg(progSerialIoOut_reg),
    .progSerialIoOeN_reg(progSerialIoOeN_reg), .sharedPinFuncEn_reg(sharedPinFuncEn_reg));

  prog_link_model link (
    .progSerialClk(progSerialClk), .progFrame(progFrame), .progSerialIoIn(progSerialIoIn),
    .progSerialIoOut_reg(progSerialIoOut_reg), .progSerialIoOeN_reg(progSerialIoOeN_reg));

  // ********
  // Shared tasks
  // ********
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic linkOp(input bit rd, input int a, input logic [13:0] d);
    link.frame('{isRead: rd, addr: a[10:0], data: d}, w, ok);
    check("link handshake", 1, ok);
  endtask : linkOp

  // One idle edge follows each write, so a second call never raises the strobe
  // in the same time step in which this one lowers it.
  task automatic ptrWr(input bit hi, input logic [7:0] d);
    ptrWrStb  = 1'b1;
    ptrWrHigh = hi;
    ptrWrData = d;
    step(1);
    ptrWrStb  = 1'b0;
    step(1);
  endtask : ptrWr

  // Expected table result: low byte to the operand, upper bits to the latch with zero fill.
  task automatic pushExp(input int a, input logic [6:0] dest);
    expQ.push_back({dest, img[a][7:0], 2'b00, img[a][13:8]});
  endtask : pushExp

  // All table reads come from the one main sequence; no handler competes for the latch.
  task automatic tabOne(input logic [6:0] dest, input bit last, input int a);
    tabRdReq      = 1'b1;
    tabRdLastPage = last;
    tabRdDest     = dest;
    pushExp(a, dest);
    step(1);
    tabRdReq      = 1'b0;
    step(3);
  endtask : tabOne

  // ********
  // Result monitor
  // ********
  always @(posedge clk_sys) begin
    #2;
    if (dataWr_reg.strobe === 1'b1) begin
      check("stall before strobe", 1, prevStall);
      if (expQ.size() == 0) begin
        check("unexpected strobe", 0, 1);
      end else begin
        e = expQ.pop_front();
        check("dest", e[22:16], dataWr_reg.addr);
        check("low byte", e[15:8], dataWr_reg.value);
        check("high latch", e[7:0], tableHighLatch_reg);
      end
    end
    if (prevStall === 1'b1) check("stall width", 0, fetchStall_reg);
    prevStall = fetchStall_reg;
  end

  initial begin
    #2ms;
    bad_count++;
    $display("CHECK FAILED watchdog expected end seen hang");
    finish_test();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    void'($urandom(76336));
    {pcNext, ptrWrStb, ptrWrHigh, ptrWrData, tabRdReq, tabRdLastPage, tabRdDest} = '0;
    fork
      step(8);
      link.pulses(3);
    join
    check("fetch in reset", 0, fetchAddr_reg);
    check("oe in reset", 1, progSerialIoOeN_reg);
    reset = 1'b0;
    step(4);
    check("reset vector", 0, fetchAddr_reg);
    check("pin func idle", 1, sharedPinFuncEn_reg);
    $display("test reset done");

    foreach (addrs[i]) begin
      img[addrs[i]] = 14'($urandom());
      linkOp(1'b0, addrs[i], img[addrs[i]]);
    end
    fork
      linkOp(1'b1, 'h306, 14'h0000);
      begin
        step(12);
        check("pin func in frame", 0, sharedPinFuncEn_reg);
      end
    join
    check("read back", img['h306], w);
    linkOp(1'b1, 'h7ff, 14'h0000);
    check("read back", img['h7ff], w);
    step(4);
    $display("test link done");

    foreach (addrs[i]) begin
      pcNext = addrs[i];
      step(1);
      check("fetch addr", addrs[i], fetchAddr_reg);
      step(1);
      check("fetch word", img[addrs[i]], instrWord_reg);
    end
    $display("test fetch done");

    pcNext = 11'h000;
    ptrWr(1'b0, 8'h06);
    ptrWr(1'b1, 8'h03);
    check("latch untouched", 0, tableHighLatch_reg);
    tabRdReq      = 1'b1;
    tabRdLastPage = 1'b0;
    tabRdDest     = 7'h11;
    pushExp('h306, 7'h11);
    step(1);
    tabRdDest = 7'h22;
    pcNext    = 11'h305;
    step(1);
    check("fetch held", 0, fetchAddr_reg);
    tabRdDest = 7'h33;
    pushExp('h306, 7'h33);
    step(1);
    tabRdReq = 1'b0;
    step(3);
    check("ptr low kept", 8'h06, tblPtrLow_reg);
    check("ptr high kept", 3'h3, tblPtrHigh_reg);
    ptrWr(1'b0, 8'h05);
    tabOne(7'h44, 1'b0, 'h305);
    ptrWr(1'b0, 8'hff);
    check("latch on ptr write", {2'b00, img['h305][13:8]}, tableHighLatch_reg);
    tabOne(7'h7f, 1'b1, 'h7ff);
    check("all results seen", 0, expQ.size());
    $display("test table read done");
    finish_test();
  end
endmodule : program_memory_table_read_tb
`default_nettype wire
